// *** fdg_glue.sv ***
/*
 * Floppy DMA transfer glue: DMA takeover, address latch, strobe pairing,
 * disk select mux, disk clock and control, priority interrupt controller
 * and the system bus exchange sequencer.
 * Assumes the inputs marked async arrive asynchronously and are synchronised here.
 */
`timescale 1ns/10ps

module fdg_glue
    import fdg_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input  wire logic              mclk,            // system clock
    input  wire logic              rstn,            // async reset, low
    // dma setup from the processor
    input  wire logic [ADDR_W-1:0] dmaStartAddr,    // first ram address
    input  wire logic [ADDR_W-1:0] dmaCount,        // bytes to move
    input  wire logic              dmaDirection,    // 1 disk to memory
    input  wire logic              dmaStart,        // arm pulse
    input  wire logic              dmaRequest,      // from disk ctrl, async
    output logic                   busTakeoverReq,  // hold to processor
    input  wire logic              busGrantAck,     // grant, async
    output logic                   dmaAcknowledgeN, // acknowledge, low
    output logic                   ramSelect,       // local ram chosen
    output logic [7:0]             lowAddr,         // low address lines
    output logic [7:0]             muxAddrData,     // high byte on mux bus
    output logic                   upperAddrEnable, // latch enable
    output logic                   upperAddrStrobe, // latch strobe
    output logic                   dmaBusy,         // transfer armed
    // processor strobes and decoded selects
    input  wire logic              cpuReadN,        // processor read
    input  wire logic              cpuWriteN,       // processor write
    input  wire logic              cpuIoMem,        // 1 io cycle
    input  wire logic              diskCtrlSelReq,  // decoded select, low
    input  wire logic [1:0]        cpuAddrLow,      // processor a0 a1
    output fdg_strobe_t            strobes,         // io and mem strobes
    output fdg_dsel_t              diskSel,         // to disk controller
    // disk controller control
    input  wire logic              resetDiskReq,    // processor reset req
    input  wire logic              halfClkReq,      // clock halving bit
    input  wire logic              calibReq,        // calibration bit
    output logic                   diskCtrlMasterResetN, // reset, low
    output logic                   densitySelectN,  // low double density
    output logic                   clockHalvingN,   // halving, low
    output logic                   calibrateN,      // calibration, low
    output logic                   diskClk,         // 2 mhz clock
    output logic                   diskClkWork,     // working clock
    // interrupt controller
    input  wire logic [IRQ_LINES-1:0] irqRaw,       // requests, async
    input  wire logic              picWrite,        // command write
    input  wire logic [1:0]        picSel,          // command select
    input  wire logic [7:0]        picData,         // command data
    input  wire logic              irqAckPulseN,    // acknowledge, async
    output logic                   cpuIrq,          // interrupt to cpu
    output logic [7:0]             vectorData,      // vector byte
    output logic                   vectorDrive,     // vector on bus
    output logic [IRQ_LINES-1:0]   inService,       // in-service bits
    // system bus exchange
    input  wire logic              systemBusRequestN, // request, low
    input  wire logic              busGrantN,       // system grant, async
    output logic [SEQ_TAPS-1:0]    seqTaps,         // shift taps
    output logic                   sysByteStrobe,   // one per byte
    output logic                   sysCycleDone     // cycle end pulse
);

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    localparam int NSYNC = IRQ_LINES + 4;
    // idle pin levels: no request, no grant, ack and system grant high
    localparam logic [NSYNC-1:0] SYNC_IDLE = {IRQ_LINES'(0), 4'h3};
    logic [NSYNC-1:0] syncA_r, syncB_r;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            syncA_r <= SYNC_IDLE;
            syncB_r <= SYNC_IDLE;
        end else begin
            syncA_r <= {irqRaw, dmaRequest, busGrantAck, irqAckPulseN,
                        busGrantN};
            syncB_r <= syncA_r;
        end
    end
    logic [IRQ_LINES-1:0] irqS;
    logic dreqS, hldaS, intaNS, grantNS;
    assign {irqS, dreqS, hldaS, intaNS, grantNS} = syncB_r;

    // ****************************************************************
    // dma engine
    // ****************************************************************
    fdg_dma_state_t   dmaSt_r, dmaSt_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt, cnt_r, cnt_nxt;
    logic              dir_r, dir_nxt, armed_r, armed_nxt;
    always_comb begin
        dmaSt_nxt = dmaSt_r;
        addr_nxt  = addr_r;
        cnt_nxt   = cnt_r;
        dir_nxt   = dir_r;
        armed_nxt = armed_r;
        if (dmaStart && dmaSt_r == DMA_IDLE) begin
            addr_nxt  = dmaStartAddr;
            cnt_nxt   = dmaCount;
            dir_nxt   = dmaDirection;
            armed_nxt = (dmaCount != '0);
        end
        case (dmaSt_r)
            DMA_IDLE: if (armed_r && dreqS) dmaSt_nxt = DMA_HOLD;
            DMA_HOLD: if (hldaS) dmaSt_nxt = DMA_ADDR;
            DMA_ADDR: dmaSt_nxt = DMA_XFER;
            DMA_XFER: begin
                addr_nxt  = addr_r + ADDR_W'(1);
                cnt_nxt   = cnt_r - ADDR_W'(1);
                armed_nxt = (cnt_r != ADDR_W'(1));
                dmaSt_nxt = DMA_DONE;
            end
            DMA_DONE: begin
                // acknowledge off; drop hold unless more is asked
                if (!dreqS || !armed_r) dmaSt_nxt = DMA_IDLE;
                else if (!dreqS) dmaSt_nxt = DMA_IDLE;
                else dmaSt_nxt = DMA_ADDR;
            end
            default: dmaSt_nxt = DMA_IDLE;
        endcase
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dmaSt_r <= DMA_IDLE;
            addr_r  <= '0;
            cnt_r   <= '0;
            dir_r   <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            dmaSt_r <= dmaSt_nxt;
            addr_r  <= addr_nxt;
            cnt_r   <= cnt_nxt;
            dir_r   <= dir_nxt;
            armed_r <= armed_nxt;
        end
    end

    logic ackActive;
    assign ackActive       = (dmaSt_r == DMA_ADDR) || (dmaSt_r == DMA_XFER);
    assign busTakeoverReq  = (dmaSt_r != DMA_IDLE);
    assign dmaAcknowledgeN = !ackActive;
    assign ramSelect       = hldaS;
    assign lowAddr         = addr_r[7:0];
    assign muxAddrData     = addr_r[ADDR_W-1:ADDR_W-8];
    assign upperAddrEnable = busTakeoverReq && hldaS;
    assign upperAddrStrobe = (dmaSt_r == DMA_ADDR);
    assign dmaBusy         = armed_r;

    // ****************************************************************
    // strobe pairing and disk select mux
    // ****************************************************************
    always_comb begin
        strobes = '1;
        if (hldaS) begin
            if (dmaSt_r == DMA_XFER) begin
                if (dir_r == FDG_DISK_TO_MEM) begin
                    strobes.ioReadN   = 1'b0;
                    strobes.memWriteN = 1'b0;
                end else begin
                    strobes.ioWriteN  = 1'b0;
                    strobes.memReadN  = 1'b0;
                end
            end
        end else if (cpuIoMem) begin
            strobes.ioReadN  = cpuReadN;
            strobes.ioWriteN = cpuWriteN;
        end else begin
            strobes.memReadN  = cpuReadN;
            strobes.memWriteN = cpuWriteN;
        end
    end
    always_comb begin
        if (dmaAcknowledgeN) begin
            diskSel.selectN = diskCtrlSelReq;
            diskSel.addr    = cpuAddrLow;
        end else begin
            diskSel.selectN = 1'b0;
            diskSel.addr    = DATA_REG_ADR;
        end
    end

    // ****************************************************************
    // disk controller clock and control
    // ****************************************************************
    logic [7:0] dDiv_r, dDiv_nxt;
    logic       dClk_r, dClk_nxt, wClk_r, wClk_nxt;
    logic       rst_r, half_r, cal_r;
    always_comb begin
        dDiv_nxt = dDiv_r + 8'h01;
        dClk_nxt = dClk_r;
        wClk_nxt = wClk_r;
        if (dDiv_r == 8'(DCLK_HALF - 1)) begin
            dDiv_nxt = '0;
            dClk_nxt = !dClk_r;
            if (!dClk_r) wClk_nxt = half_r ? !wClk_r : !dClk_r;
            else if (!half_r) wClk_nxt = 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dDiv_r <= '0;
            dClk_r <= 1'b0;
            wClk_r <= 1'b0;
            rst_r  <= 1'b0;
            half_r <= 1'b0;
            cal_r  <= 1'b0;
        end else begin
            dDiv_r <= dDiv_nxt;
            dClk_r <= dClk_nxt;
            wClk_r <= wClk_nxt;
            rst_r  <= resetDiskReq;
            half_r <= halfClkReq;
            cal_r  <= calibReq;
        end
    end
    assign diskClk              = dClk_r;
    assign diskClkWork          = wClk_r;
    assign diskCtrlMasterResetN = !rst_r;
    assign densitySelectN       = 1'b0;
    assign clockHalvingN        = !half_r;
    assign calibrateN           = !cal_r;

    // ****************************************************************
    // priority interrupt controller
    // ****************************************************************
    fdg_pic_state_t       picSt_r, picSt_nxt;
    logic [IRQ_LINES-1:0] irr_r, irr_nxt, isr_r, isr_nxt;
    logic [IRQ_LINES-1:0] imr_r, imr_nxt, prev_r;
    logic [2:0]           low_r, low_nxt, sel_r, sel_nxt;
    logic [4:0]           vb_r, vb_nxt;
    logic                 inta1_r;
    logic                 reqHit, isHit;
    logic [2:0]           reqId, isId;

    // lowest-priority line is low_r; search from the line after it
    always_comb begin
        logic [2:0] k;
        reqHit = 1'b0;
        isHit  = 1'b0;
        reqId  = '0;
        isId   = '0;
        k      = '0;
        for (int i = IRQ_LINES - 1; i >= 0; i--) begin
            k = low_r + 3'(i + 1);
            if (isr_r[k]) begin
                isHit = 1'b1;
                isId  = k;
            end
        end
        for (int i = IRQ_LINES - 1; i >= 0; i--) begin
            k = low_r + 3'(i + 1);
            if (irr_r[k] && !imr_r[k]
                && (!isHit || 3'(k + ~low_r) < 3'(isId + ~low_r))) begin
                reqHit = 1'b1;
                reqId  = k;
            end
        end
    end

    always_comb begin
        picSt_nxt = picSt_r;
        irr_nxt   = irr_r | (irqS & ~prev_r);
        isr_nxt   = isr_r;
        imr_nxt   = imr_r;
        low_nxt   = low_r;
        sel_nxt   = sel_r;
        vb_nxt    = vb_r;
        if (picWrite) begin
            case (picSel)
                PIC_MASK:    imr_nxt = picData;
                PIC_ROTATE:  low_nxt = picData[2:0];
                PIC_EOI:     isr_nxt = isr_r & ~picData;
                PIC_VECBASE: vb_nxt  = picData[7:3];
                default:     ;
            endcase
        end
        case (picSt_r)
            PIC_IDLE: if (!intaNS && inta1_r) begin
                sel_nxt   = reqId;
                picSt_nxt = PIC_ACK1;
                if (reqHit) begin
                    isr_nxt[reqId] = 1'b1;
                    // a fresh edge in the ack cycle stays pending
                    irr_nxt[reqId] = irqS[reqId] && !prev_r[reqId];
                end
            end
            PIC_ACK1:  if (intaNS) picSt_nxt = PIC_WAIT2;
            PIC_WAIT2: if (!intaNS) picSt_nxt = PIC_ACK2;
            PIC_ACK2:  if (intaNS) picSt_nxt = PIC_IDLE;
            default:   picSt_nxt = PIC_IDLE;
        endcase
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            picSt_r <= PIC_IDLE;
            irr_r   <= '0;
            isr_r   <= '0;
            imr_r   <= '0;
            prev_r  <= '0;
            low_r   <= 3'(IRQ_LINES - 1);
            sel_r   <= '0;
            vb_r    <= VEC_BASE_RST;
            inta1_r <= 1'b1;
        end else begin
            picSt_r <= picSt_nxt;
            irr_r   <= irr_nxt;
            isr_r   <= isr_nxt;
            imr_r   <= imr_nxt;
            prev_r  <= irqS;
            low_r   <= low_nxt;
            sel_r   <= sel_nxt;
            vb_r    <= vb_nxt;
            inta1_r <= intaNS;
        end
    end
    assign cpuIrq      = reqHit && (picSt_r == PIC_IDLE);
    assign vectorDrive = (picSt_r == PIC_ACK2);
    assign vectorData  = {vb_r, sel_r};
    assign inService   = isr_r;

    // ****************************************************************
    // system bus exchange sequencer
    // ****************************************************************
    logic [SEQ_TAPS-1:0] sh_r, sh_nxt;
    logic [1:0]          bytes_r, bytes_nxt;
    logic                seqRun;
    assign seqRun = !systemBusRequestN && !grantNS;
    always_comb begin
        sh_nxt    = {sh_r[SEQ_TAPS-2:0], 1'b0};
        bytes_nxt = bytes_r;
        if (!seqRun) begin
            sh_nxt    = '0;
            bytes_nxt = '0;
        end else if (sh_r == '0 && bytes_r < 2'(SYS_BYTES)) begin
            sh_nxt = {{(SEQ_TAPS-1){1'b0}}, 1'b1};
        end
        if (seqRun && sh_r[SEQ_TAPS-1]) bytes_nxt = bytes_r + 2'h1;
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sh_r    <= '0;
            bytes_r <= '0;
        end else begin
            sh_r    <= sh_nxt;
            bytes_r <= bytes_nxt;
        end
    end
    assign seqTaps       = sh_r;
    assign sysByteStrobe = sh_r[SEQ_TAPS-1];
    assign sysCycleDone  = sh_r[SEQ_TAPS-1]
                           && (bytes_r == 2'(SYS_BYTES - 1));

endmodule : fdg_glue

// *** fdg_pkg.sv ***
/*
 * Constants, types and state enumerations for the floppy DMA transfer glue.
 * Assumes a single 100 MHz clock domain and the active-low async reset rstn.
 */
//
// Behaviour
// - on bus grant low, a single one shifts through the timing shift register.
// - exactly two bytes move each time the shared bus is held.
// - eight active-high requests, highest priority resolved, order programmable.
// - processor interrupt raised only if request outranks the one in service.
// - first acknowledge pulse picks request, second drives vector onto data bus.
// - input 0 power, 1 disk done, 2 system, 3/4 disk change, 7 index.
// - disk controller raises DMA request when data register full or empty.
// - DMA engine pulls its active-low acknowledge low on a DMA request.
// - takeover request asserted, transfer waits for the grant acknowledge.
// - grant acknowledge high also selects the local RAM.
// - low address direct, high byte latched via enable and strobe pulse.
// - mem-to-disk uses io write plus mem read; disk-to-mem the reverse.
// - acknowledge high passes decoded select and processor address bits.
// - acknowledge low forces select active and both address bits high.
// - disk controller raises completion interrupt at the end of each command.
// - disk controller reset is active low and it runs from 2 MHz.
// - density input held low selects double density.
// - clock halving asserted divides the controller clock to 1 MHz.
// - calibration output driven low enters calibration mode.
// - processor strobe mux is enabled only while grant acknowledge is low.
package fdg_pkg;

    localparam int          CLK_MHZ      = 100;
    localparam int          DCLK_MHZ     = 2;
    localparam int          DCLK_HALF    = CLK_MHZ / (2 * DCLK_MHZ);
    localparam int          SEQ_TAPS     = 8;
    localparam int          SYS_BYTES    = 2;
    localparam int          IRQ_LINES    = 8;
    localparam logic [4:0]  VEC_BASE_RST = 5'h08;
    localparam logic [1:0]  DATA_REG_ADR = 2'h3;
    localparam logic [2:0]  IRQ_DISKDONE = 3'h1;

    // priority controller command port selectors
    localparam logic [1:0]  PIC_MASK     = 2'h0;
    localparam logic [1:0]  PIC_ROTATE   = 2'h1;
    localparam logic [1:0]  PIC_EOI      = 2'h2;
    localparam logic [1:0]  PIC_VECBASE  = 2'h3;

    typedef enum logic {
        FDG_MEM_TO_DISK,
        FDG_DISK_TO_MEM
    } fdg_dir_t;

    typedef enum {
        DMA_IDLE,
        DMA_HOLD,
        DMA_ADDR,
        DMA_XFER,
        DMA_DONE
    } fdg_dma_state_t;

    typedef enum {
        PIC_IDLE,
        PIC_ACK1,
        PIC_WAIT2,
        PIC_ACK2
    } fdg_pic_state_t;

    // active-low strobe group
    typedef struct packed {
        logic ioReadN;
        logic ioWriteN;
        logic memReadN;
        logic memWriteN;
    } fdg_strobe_t;

    // disk-controller select and address group
    typedef struct packed {
        logic       selectN;
        logic [1:0] addr;
    } fdg_dsel_t;

endpackage : fdg_pkg

// *** fdg_glue_props.sv ***
/* assertions on the ports of fdg_glue
   bound to every fdg_glue instance; one mclk domain, rstn async low */
`timescale 1ns/10ps
module fdg_glue_props
    import fdg_pkg::*;
(
    input wire logic                mclk,            // clock
    input wire logic                rstn,            // reset, low
    input wire logic                dmaAcknowledgeN, // ack, low
    input wire logic                dmaDirection,    // 1 disk to mem
    input wire logic                busTakeoverReq,  // hold request
    input wire logic                ramSelect,       // ram chosen
    input wire logic                upperAddrEnable, // latch enable
    input wire logic                upperAddrStrobe, // latch strobe
    input wire logic                diskCtrlSelReq,  // decoded select
    input wire logic [1:0]          cpuAddrLow,      // cpu a0 a1
    input wire fdg_strobe_t         strobes,         // strobe group
    input wire fdg_dsel_t           diskSel,         // disk select
    input wire logic                resetDiskReq,    // reset request
    input wire logic                halfClkReq,      // halving request
    input wire logic                calibReq,        // calib request
    input wire logic                diskCtrlMasterResetN, // reset out
    input wire logic                densitySelectN,  // density out
    input wire logic                clockHalvingN,   // halving out
    input wire logic                calibrateN,      // calib out
    input wire logic [SEQ_TAPS-1:0] seqTaps          // shift taps
);
    // ************************************
    // properties
    // ************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    property p_mux_dma;
        !dmaAcknowledgeN |-> diskSel == {1'b0, DATA_REG_ADR};
    endproperty
    a_mux_dma: assert property (p_mux_dma) else $error("mux dma");
    property p_mux_cpu;
        dmaAcknowledgeN |-> diskSel == {diskCtrlSelReq, cpuAddrLow};
    endproperty
    a_mux_cpu: assert property (p_mux_cpu) else $error("mux cpu");
    property p_ack_len;
        $fell(dmaAcknowledgeN) |=> !dmaAcknowledgeN ##1 dmaAcknowledgeN;
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack len");
    property p_hold;
        !dmaAcknowledgeN |-> busTakeoverReq && ramSelect;
    endproperty
    a_hold: assert property (p_hold) else $error("no grant");
    property p_latch;
        upperAddrStrobe |-> upperAddrEnable && !dmaAcknowledgeN
            ##1 !upperAddrStrobe;
    endproperty
    a_latch: assert property (p_latch) else $error("latch");
    property p_pair;
        !dmaAcknowledgeN && strobes != 4'hf
            |-> strobes == (dmaDirection ? 4'h6 : 4'h9);
    endproperty
    a_pair: assert property (p_pair) else $error("pair");
    property p_ctl;
        {densitySelectN, diskCtrlMasterResetN, clockHalvingN, calibrateN}
            == {1'b0, ~$past({resetDiskReq, halfClkReq, calibReq})};
    endproperty
    a_ctl: assert property (p_ctl) else $error("ctl");
    property p_taps;
        $onehot0(seqTaps);
    endproperty
    a_taps: assert property (p_taps) else $error("taps");
endmodule : fdg_glue_props

bind fdg_glue fdg_glue_props u_props (.*);

// *** fdg_partner.sv ***
/* far side of fdg_glue: disk controller request and completion, and the
   local processor's bus grant; the bench loads a byte count and a lag */
`timescale 1ns/10ps
module fdg_partner
    import fdg_pkg::*;
(
    input wire logic        mclk,            // clock
    input wire logic        rstn,            // reset, low
    input wire logic        busTakeoverReq,  // hold from engine
    input wire logic        dmaAcknowledgeN, // ack from engine
    input wire logic        load,            // start a command
    input wire logic [15:0] dmaCount,        // bytes in command
    input wire logic [2:0]  lag,             // grant delay
    output logic            dmaRequest,      // data register ready
    output logic            busGrantAck,     // bus released
    output logic            cmdDone          // command finished
);
    int   pend;
    int   wt;
    logic ackQ;

    assign dmaRequest = (pend > 0);
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pend <= 0;
            wt <= 0;
            ackQ <= 1'b1;
            busGrantAck <= 1'b0;
            cmdDone <= 1'b0;
        end else begin
            ackQ <= dmaAcknowledgeN;
            if (load) begin
                pend <= int'(dmaCount);
                cmdDone <= 1'b0;
            end else if (ackQ && !dmaAcknowledgeN && pend > 0) begin
                pend <= pend - 1;
                cmdDone <= (pend == 1);
            end
            if (!busTakeoverReq) begin
                wt <= 0;
                busGrantAck <= 1'b0;
            end else if (wt >= int'(lag)) begin
                busGrantAck <= 1'b1;
            end else begin
                wt <= wt + 1;
            end
        end
    end
endmodule : fdg_partner

// *** fdg_glue_tb.sv ***
/* self-checking bench for fdg_glue
   assumes fdg_pkg, fdg_partner and the bound checker compile first */
`timescale 1ns/10ps
module fdg_glue_tb;
    import fdg_pkg::*;
    logic        mclk = 1'b0, rstn = 1'b0, dmaStart = 1'b0, load = 1'b0;
    logic        dmaDirection = 1'b0, cpuReadN = 1'b1, cpuWriteN = 1'b1;
    logic        cpuIoMem = 1'b0, diskCtrlSelReq = 1'b1, calibReq = 1'b0;
    logic        resetDiskReq = 1'b0, halfClkReq = 1'b0, picWrite = 1'b0;
    logic        irqAckPulseN = 1'b1, systemBusRequestN = 1'b1;
    logic        busGrantN = 1'b1, dmaRequest, busTakeoverReq, busGrantAck;
    logic        dmaAcknowledgeN, ramSelect, upperAddrEnable, dmaBusy;
    logic        upperAddrStrobe, diskCtrlMasterResetN, densitySelectN;
    logic        clockHalvingN, calibrateN, diskClk, diskClkWork, cpuIrq;
    logic        vectorDrive, sysByteStrobe, sysCycleDone, cmdDone;
    logic [15:0] dmaStartAddr = 16'h0, dmaCount = 16'h0, nextA = 16'h0;
    logic [1:0]  cpuAddrLow = 2'h0, picSel = 2'h0;
    logic [2:0]  lag = 3'h0;
    logic [7:0]  picData = 8'h0, irqV = 8'h0, lowAddr, muxAddrData;
    logic [7:0]  vectorData, inService, seqTaps;
    fdg_strobe_t strobes;
    fdg_dsel_t   diskSel;
    int          fails = 0, cmp_count = 0, nSeen = 0, nb = 0;
    int          nClk = 0, nWork = 0;
    logic        dClkQ = 1'b0, wClkQ = 1'b0;
    wire logic [7:0] irqRaw = irqV | {6'h0, cmdDone, 1'b0};

    fdg_glue dut (.*);
    fdg_partner partner (.*);

    always #5 mclk = ~mclk;
    initial begin
        #400000;
        fails++;
        results();
    end
    // ************************************
    // model and checks
    // ************************************
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    always @(negedge mclk) begin
        if (rstn && upperAddrStrobe === 1'b1) begin
            chk("addr", nextA, {muxAddrData, lowAddr});
            nextA++;
            nSeen++;
        end
        if (ramSelect === 1'b1 && 4'(strobes) !== 4'hf)
            chk("pair", dmaDirection ? 16'h6 : 16'h9, 16'(strobes));
    end

    // half periods of the disk clocks; the first starts a cycle late
    always @(negedge mclk) begin
        nClk = rstn ? nClk + 1 : -1;
        nWork = rstn ? nWork + 1 : -1;
        if (diskClk !== dClkQ) begin
            chk("dclk", 16'(DCLK_HALF), 16'(nClk));
            nClk = 0;
        end
        if (diskClkWork !== wClkQ) begin
            chk("wclk", 16'(halfClkReq ? 2 * DCLK_HALF : DCLK_HALF),
                16'(nWork));
            nWork = 0;
        end
        dClkQ = diskClk;
        wClkQ = diskClkWork;
    end

    task automatic pic(logic [1:0] s, logic [7:0] d);
        picSel <= s;
        picData <= d;
        picWrite <= 1'b1;
        @(posedge mclk);
        picWrite <= 1'b0;
        @(posedge mclk);
    endtask : pic

    task automatic intack(logic [2:0] id);
        for (int t = 0; t < 40 && cpuIrq !== 1'b1; t++) @(posedge mclk);
        chk("irq", 16'h1, 16'(cpuIrq));
        for (int k = 0; k < 4; k++) begin
            irqAckPulseN <= k[0];
            repeat (4) @(posedge mclk);
            if (k == 2) begin
                chk("vec", {8'h1, VEC_BASE_RST, id},
                    {7'h0, vectorDrive, vectorData});
                chk("isr", 16'(8'h1 << id), 16'(inService));
            end
        end
        chk("nest", 16'h0, 16'(cpuIrq));
        pic(PIC_EOI, 8'h1 << id);
    endtask : intack

    task automatic dma(int n, logic d);
        nextA = {8'($urandom), 8'hfe};
        dmaStartAddr <= nextA;
        dmaCount <= 16'(n);
        dmaDirection <= d;
        lag <= 3'($urandom_range(4));
        load <= 1'b1;
        dmaStart <= 1'b1;
        @(posedge mclk);
        load <= 1'b0;
        dmaStart <= 1'b0;
        nSeen = 0;
        for (int t = 0; t < 400 && (nSeen < n || busTakeoverReq !== 1'b0);
             t++) @(posedge mclk);
        chk("bytes", 16'(n), 16'(nSeen));
        chk("hold", 16'h0, 16'(busTakeoverReq));
        chk("busy", 16'h0, 16'(dmaBusy));
    endtask : dma
    // ************************************
    // sequence
    // ************************************
    initial begin
        void'($urandom(98022));
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        repeat (20) begin
            @(posedge mclk);
            {resetDiskReq, halfClkReq, calibReq, diskCtrlSelReq, cpuAddrLow}
                <= 6'($urandom);
        end
        dma(3, 1'b0);
        intack(IRQ_DISKDONE);
        dma(2, 1'b1);
        intack(IRQ_DISKDONE);
        for (int i = 0; i < IRQ_LINES; i++) begin
            if (i != int'(IRQ_DISKDONE)) begin
                irqV <= 8'h1 << i;
                intack(3'(i));
            end
        end
        irqV <= 8'h28;
        intack(3'h3);
        intack(3'h5);
        pic(PIC_ROTATE, 8'h02);
        irqV <= 8'h11;
        intack(3'h4);
        intack(3'h0);
        pic(PIC_MASK, 8'h40);
        irqV <= 8'h44;
        intack(3'h2);
        systemBusRequestN <= 1'b0;
        busGrantN <= 1'b0;
        nSeen = 0;
        repeat (80) begin
            @(posedge mclk);
            nb += int'(sysByteStrobe);
            nSeen += int'(sysCycleDone);
        end
        chk("sysb", 16'(SYS_BYTES), 16'(nb));
        chk("sysd", 16'h1, 16'(nSeen));
        results();
    end
endmodule : fdg_glue_tb
